// ==== scrambled_greyscale_pwm_defs.svh ====
// Constants of the scrambled greyscale PWM generator.
// Assumes inclusion by bare name; definitions only.
`ifndef SCRAMBLED_GREYSCALE_PWM_DEFS_SVH
`define SCRAMBLED_GREYSCALE_PWM_DEFS_SVH

`define SYS_CLK_PERIOD_NS 5
`define PWM_STEP_NS 100
`define PWM_DIV_CYCLES ((`PWM_STEP_NS / `SYS_CLK_PERIOD_NS) < 1 ? 1 : \
    (`PWM_STEP_NS / `SYS_CLK_PERIOD_NS))
`define DIV_W 5
`define CHANNELS 12
`define GREY_W 12
`define GREY_BUS_W 144
`define GREY_RESET 12'h000
`define CYCLE_LAST 12'hFFF
`define POS_RESET 12'h000
`define SUB_W 5
`define SLOT_W 7
`define DIV_RESET 5'h00

`endif

// ==== scrambled_pwm_pkg.sv ====
// Types of the scrambled greyscale PWM generator.
// Assumes the defs header supplies all numeric constants.
package scrambled_pwm_pkg;
    typedef enum logic {ST_RUN, ST_HALT} run_state_e;
endpackage

// ==== subperiod_scatter.sv ====
// One channel's on/off decision at a given PWM clock position.
// Assumes position and value are stable registered signals.
`timescale 1ns/1ps
`include "scrambled_greyscale_pwm_defs.svh"

module subperiod_scatter (
    input wire logic [11:0] pos,
    input wire logic [11:0] value,
    output logic on
);
    function automatic logic [6:0] bit_reverse7(input logic [6:0] s);
        logic [6:0] r;
        for (int i = 0; i < 7; i++) begin
            r[i] = s[6 - i];
        end
        return r;
    endfunction

    logic [4:0] remainder;
    logic [6:0] quota;
    logic [11:0] shifted;
    logic [6:0] slot;

    always_comb begin
        remainder = value[`SUB_W-1:0];
        quota = value[11:`SUB_W];
        shifted = pos - {7'h00, remainder};
        slot = shifted[11:`SUB_W];
        // Leftover clocks lead the cycle [RULE3]
        if (pos < {7'h00, remainder}) begin
            on = 1'b1;
        end else begin
            // Bit-reversed slot order spreads 32-clock pieces evenly [RULE1] [RULE2] [RULE10]
            on = (bit_reverse7(slot) < quota);
        end
    end
endmodule

// ==== scrambled_greyscale_pwm.sv ====
// Twelve-channel scrambled greyscale PWM generator.
// Assumes load, data and config bits come from serial logic on clk.
// What this block does
// RULE1: Scatter each channel's on-time across the cycle
// RULE2: Split on-time into 32-clock sub-periods, spread evenly
// RULE3: Leftover clocks go at the cycle start
// RULE4: PWM step is a 10 MHz internal clock
// RULE5: On for exactly greyscale value clocks per cycle
// RULE6: 4096-clock cycle repeats until off or reloaded
// RULE7: Twelve 12-bit greyscale values, reset to zero
// RULE8: Run-once bit stops after a single cycle
// RULE9: Disable bit forces all outputs off
// RULE10: Fixed slot positions give deterministic patterns
`timescale 1ns/1ps
`include "scrambled_greyscale_pwm_defs.svh"

module scrambled_greyscale_pwm (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic greyscale_load,
    input wire logic [`GREY_BUS_W-1:0] greyscale_value,
    input wire logic outputs_disable,
    input wire logic run_once,
    output logic [`CHANNELS-1:0] channel_sink_outputs,
    output logic cycle_running
);
    logic rst_meta_r;
    logic rst_sync_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_b <= rst_meta_r;
        end
    end

    // Timebase
    logic [`DIV_W-1:0] div_cnt_r, div_cnt_nxt;
    logic [11:0] pos_r, pos_nxt;
    scrambled_pwm_pkg::run_state_e state_r, state_nxt;
    logic tick;
    logic cycle_end;

    always_comb begin
        tick = (div_cnt_r == `DIV_W'(`PWM_DIV_CYCLES - 1));
        cycle_end = tick && (pos_r == `CYCLE_LAST);
        div_cnt_nxt = tick ? `DIV_RESET : div_cnt_r + `DIV_W'(1); // [RULE4]
        pos_nxt = pos_r;
        state_nxt = state_r;
        if (greyscale_load) begin
            // New data restarts the cycle [RULE6]
            div_cnt_nxt = `DIV_RESET;
            pos_nxt = `POS_RESET;
            state_nxt = scrambled_pwm_pkg::ST_RUN;
        end else begin
            case (state_r)
                scrambled_pwm_pkg::ST_RUN: begin
                    if (tick) begin
                        pos_nxt = pos_r + 12'h001; // [RULE6]
                    end
                    if (cycle_end && run_once) begin
                        state_nxt = scrambled_pwm_pkg::ST_HALT; // [RULE8]
                    end
                end
                default: begin
                    // Clearing run-once resumes endless running
                    if (!run_once) begin
                        state_nxt = scrambled_pwm_pkg::ST_RUN;
                        pos_nxt = `POS_RESET;
                        div_cnt_nxt = `DIV_RESET;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            div_cnt_r <= `DIV_RESET;
            pos_r <= `POS_RESET;
            state_r <= scrambled_pwm_pkg::ST_RUN;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            pos_r <= pos_nxt;
            state_r <= state_nxt;
        end
    end

    // Greyscale store
    logic [`GREY_W-1:0] grey_r [`CHANNELS];
    logic [`GREY_W-1:0] grey_nxt [`CHANNELS];

    always_comb begin
        for (int n = 0; n < `CHANNELS; n++) begin
            grey_nxt[n] = greyscale_load ? greyscale_value[n*`GREY_W +: `GREY_W] : grey_r[n]; // [RULE7]
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            for (int n = 0; n < `CHANNELS; n++) begin
                grey_r[n] <= `GREY_RESET; // [RULE7]
            end
        end else begin
            grey_r <= grey_nxt;
        end
    end

    // Channel pattern and output stage
    logic [`CHANNELS-1:0] on;
    logic [`CHANNELS-1:0] out_nxt;
    logic running_nxt;

    for (genvar g = 0; g < `CHANNELS; g++) begin : g_chan
        subperiod_scatter u_scatter (
            .pos(pos_r),
            .value(grey_r[g]),
            .on(on[g])
        );
    end

    always_comb begin
        running_nxt = (state_nxt == scrambled_pwm_pkg::ST_RUN);
        if (outputs_disable || state_r != scrambled_pwm_pkg::ST_RUN) begin
            out_nxt = '0; // [RULE9]
        end else begin
            out_nxt = on; // [RULE5]
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            channel_sink_outputs <= '0;
            cycle_running <= 1'b0;
        end else begin
            channel_sink_outputs <= out_nxt;
            cycle_running <= running_nxt;
        end
    end

    // Checking helpers: on-clock count of channel 0 over one cycle
    logic [12:0] on_cnt_r, on_cnt_nxt;

    always_comb begin
        on_cnt_nxt = on_cnt_r;
        // Halted time must not leak into the next cycle's count
        if (greyscale_load || cycle_end || state_r != scrambled_pwm_pkg::ST_RUN) begin
            on_cnt_nxt = 13'h0000;
        end else if (tick) begin
            on_cnt_nxt = on_cnt_r + {12'h000, on[0]};
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            on_cnt_r <= 13'h0000;
        end else begin
            on_cnt_r <= on_cnt_nxt;
        end
    end

    property p_tick_spacing;
        @(posedge clk) disable iff (!rst_sync_b)
        tick |=> !tick [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) // [RULE4]
        else $error("PWM step shorter than expected");

    property p_cycle_wrap;
        @(posedge clk) disable iff (!rst_sync_b)
        (cycle_end && !run_once && !greyscale_load) |=> (pos_r == 12'h000 && cycle_running);
    endproperty
    a_cycle_wrap: assert property (p_cycle_wrap) // [RULE6]
        else $error("Cycle did not restart after 4096 steps");

    property p_run_once_stop;
        @(posedge clk) disable iff (!rst_sync_b)
        (cycle_end && run_once && !greyscale_load) |=> !cycle_running ##1 (channel_sink_outputs == '0);
    endproperty
    a_run_once_stop: assert property (p_run_once_stop) // [RULE8]
        else $error("Outputs active after single cycle");

    property p_disable;
        @(posedge clk) disable iff (!rst_sync_b)
        outputs_disable |=> (channel_sink_outputs == '0);
    endproperty
    a_disable: assert property (p_disable) // [RULE9]
        else $error("Output active while disabled");

    property p_load;
        @(posedge clk) disable iff (!rst_sync_b)
        greyscale_load |=> (grey_r[11] == $past(greyscale_value[143:132]) && pos_r == 12'h000);
    endproperty
    a_load: assert property (p_load) // [RULE7]
        else $error("Greyscale value not loaded");

    property p_remainder_first;
        @(posedge clk) disable iff (!rst_sync_b)
        (state_r == scrambled_pwm_pkg::ST_RUN && !outputs_disable && !greyscale_load
            && pos_r < {7'h00, grey_r[0][4:0]}) |=> channel_sink_outputs[0];
    endproperty
    a_remainder_first: assert property (p_remainder_first) // [RULE3]
        else $error("Leftover clocks not at cycle start");

    property p_no_subperiod;
        @(posedge clk) disable iff (!rst_sync_b)
        (grey_r[0][11:5] == 7'h00 && pos_r >= {7'h00, grey_r[0][4:0]}) |-> !on[0];
    endproperty
    a_no_subperiod: assert property (p_no_subperiod) // [RULE2]
        else $error("Sub-period output without quota");

    property p_on_count;
        @(posedge clk) disable iff (!rst_sync_b)
        (cycle_end && !greyscale_load) |-> (on_cnt_r + {12'h000, on[0]} == {1'b0, grey_r[0]});
    endproperty
    a_on_count: assert property (p_on_count) // [RULE5] [RULE1]
        else $error("On-time per cycle differs from greyscale value");

    property p_deterministic;
        @(posedge clk) disable iff (!rst_sync_b)
        (grey_r[0] == grey_r[1]) |-> (on[0] == on[1]);
    endproperty
    a_deterministic: assert property (p_deterministic) // [RULE10]
        else $error("Equal values give different patterns");
endmodule

// ==== led_load_model.sv ====
// LED loads on the sink outputs: counts lit clocks per channel.
// Assumes outputs are registered on rising clk; clear is synchronous.
`timescale 1ns/1ps
`include "scrambled_greyscale_pwm_defs.svh"

module led_load_model (
    input wire logic clk,
    input wire logic clear,
    input wire logic [`CHANNELS-1:0] sink_on,
    output logic [16:0] on_clocks [`CHANNELS]
);
    always @(posedge clk) begin
        for (int i = 0; i < `CHANNELS; i++) begin
            on_clocks[i] <= clear ? 17'h0 : on_clocks[i] + 17'(sink_on[i]);
        end
    end
endmodule

// ==== tb_top.sv ====
// Testbench: one full run-once cycle, reload abort and output disable.
// Assumes the design's fixed 20-clock step and 4096-step cycle.
`timescale 1ns/1ps
`include "scrambled_greyscale_pwm_defs.svh"

module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic greyscale_load = 1'b0;
    logic [`GREY_BUS_W-1:0] greyscale_value = '0;
    logic outputs_disable = 1'b0;
    logic run_once = 1'b1;
    logic clear = 1'b1;
    logic [`CHANNELS-1:0] channel_sink_outputs;
    logic cycle_running;
    logic [16:0] on_clocks [`CHANNELS];
    int fails = 0;
    int comparisons = 0;
    // Channels 0 and 1 equal for a_deterministic; value 12'h014 gives channel 0 a leftover
    logic [11:0] vals [`CHANNELS] = '{12'h014, 12'h014, 12'h020, 12'h021, 12'hFFF, 12'h040,
        12'h000, 12'h001, 12'h01F, 12'h800, 12'hFE0, 12'h1F4};
    int chk_p [8] = '{19, 20, 0, 33, 32, 2048, 4094, 4095};
    int chk_c [8] = '{1, 1, 3, 3, 5, 5, 4, 4};
    logic chk_e [8] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};

    always #2.5 clk = ~clk;

    scrambled_greyscale_pwm dut (
        .clk(clk),
        .rst_b(rst_b),
        .greyscale_load(greyscale_load),
        .greyscale_value(greyscale_value),
        .outputs_disable(outputs_disable),
        .run_once(run_once),
        .channel_sink_outputs(channel_sink_outputs),
        .cycle_running(cycle_running)
    );

    led_load_model leds (
        .clk(clk),
        .clear(clear),
        .sink_on(channel_sink_outputs),
        .on_clocks(on_clocks)
    );

    task automatic check_val(input logic [16:0] got, input logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic final_report();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Ends at the first falling edge after the taking edge
    task automatic load_values();
        @(negedge clk);
        for (int i = 0; i < `CHANNELS; i++) begin
            greyscale_value[12*i +: 12] = vals[i];
        end
        greyscale_load = 1'b1;
        @(negedge clk);
        greyscale_load = 1'b0;
    endtask

    task automatic one_cycle_test();
        int n;
        run_once = 1'b1;
        clear = 1'b0;
        load_values();
        for (n = 2; n < 83000 && cycle_running !== 1'b0; n++) begin
            @(negedge clk);
            for (int k = 0; k < 8; k++) begin
                if (n == 13 + 20 * chk_p[k]) begin
                    check_val(17'(channel_sink_outputs[chk_c[k]]), 17'(chk_e[k]));
                end
            end
        end
        if (n >= 83000) begin
            fails++;
            return;
        end
        for (int i = 0; i < `CHANNELS; i++) begin
            check_val(on_clocks[i], 17'(vals[i]) * 17'h14);
        end
        repeat (30) @(negedge clk);
        check_val(17'(cycle_running), 17'h0);
        check_val(17'(channel_sink_outputs), 17'h0);
    endtask

    task automatic reload_disable_test();
        run_once = 1'b0;
        load_values();
        repeat (600) @(negedge clk);
        check_val(17'(channel_sink_outputs[1]), 17'h0);
        load_values();
        repeat (112) @(negedge clk);
        check_val(17'(channel_sink_outputs[1]), 17'h1);
        check_val(17'(cycle_running), 17'h1);
        outputs_disable = 1'b1;
        repeat (2) @(negedge clk);
        check_val(17'(channel_sink_outputs), 17'h0);
        outputs_disable = 1'b0;
        repeat (25) @(negedge clk);
        check_val(17'(channel_sink_outputs[4]), 17'h1);
    endtask

    task automatic reset_check();
        repeat (4) @(negedge clk);
        check_val(17'(channel_sink_outputs), 17'h0);
        check_val(17'(cycle_running), 17'h1);
    endtask

    initial begin
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        reset_check();
        one_cycle_test();
        reload_disable_test();
        final_report();
    end
endmodule
